//--- verif/irq_src_model.sv
// Behavioural model of the internal interrupt sources that feed the routing block.
`timescale 1ns/1ps
`default_nettype none

module irq_src_model (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // Requested levels and pacing.
    input wire logic [3:0] want,
    input wire logic slow,
    // Levels toward the block.
    output logic [3:0] src_req
);
    logic [3:0] stage1;
    logic [3:0] stage2;

    // A slow source ripples through two extra flops, as one behind a synchroniser would.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage1 <= 4'h0;
            stage2 <= 4'h0;
            src_req <= 4'h0;
        end
        else
        begin
            stage1 <= want;
            stage2 <= stage1;
            src_req <= slow ? stage2 : want;
        end
    end
endmodule

`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the interrupt routing and serial interrupt setup block.
`include "irq_route_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk_sys;
    logic arst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic [3:0] want;
    logic slow;
    logic [3:0] src_req;
    logic [15:0] legacy_irq_line_select;
    irq_route_pkg::serial_setup_t serial_setup;
    logic irq;
    int errors;
    int cmp_count;
    logic [7:0] v;
    logic [15:0] s;

    irq_route_ctrl #(.NUM_ROUTES(4)) uut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req),
        .legacy_irq_line_select(legacy_irq_line_select), .serial_setup(serial_setup), .irq(irq));

    irq_src_model src (.clk_sys(clk_sys), .arst_n(arst_n), .want(want), .slow(slow), .src_req(src_req));

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled just past that edge.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic stop_test;
        $display("Comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic logic [15:0] route_exp(input logic [7:0] val);
        if (val[7] || val[3:0] < 4'h3 || val[3:0] == 4'h8 || val[3:0] == 4'hD)
            return 16'h0000;
        return 16'h0001 << val[3:0];
    endfunction

    function automatic logic [11:0] setup_exp(input logic [7:0] val);
        logic [3:0] st;
        case (val[1:0])
            2'h1: st = 4'h6;
            2'h2: st = 4'h8;
            default: st = 4'h4;
        endcase
        return {val[7], val[6], 6'h11 + {2'h0, val[5:2]}, st};
    endfunction

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        stop_test();
    end

    initial
    begin
        void'($urandom(32'hBB277901));
        arst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        want = 4'h0;
        slow = 1'b0;
        errors = 0;
        cmp_count = 0;
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(`ADDR_ACPI_SCI_IRQ_ROUTE, 8'h80);
        rd(`ADDR_DEVICE_BAY_IRQ_ROUTE, 8'h80);
        rd(`ADDR_SMBUS_IRQ_ROUTE, 8'h80);
        rd(`ADDR_WATCHDOG_IRQ_ROUTE, 8'h80);
        rd(`ADDR_SOFT_IRQ_REQUEST_LOW, 8'h00);
        rd(`ADDR_SOFT_IRQ_REQUEST_HIGH, 8'h00);
        rd(`ADDR_SERIAL_IRQ_CONTROL, 8'h00);
        rd(8'h50, 8'h00);
        settle(1);
        chk("reg_rdata_idle", 16'h0000, {8'h00, reg_rdata});
        chk("serial_setup", {4'h0, setup_exp(8'h00)}, {4'h0, serial_setup});
        chk("legacy_irq_line_select", 16'h0000, legacy_irq_line_select);
        // Every line code on every route, with the spare bits drawn at random, and the disable bit too for codes other than 0, 3, 9, 14 and 15.
        for (int r = 0; r < 4; r++)
        begin
            for (int c = 0; c < 16; c++)
            begin
                // Codes that the line checks and the reserved-code event rely on always go in enabled.
                v = {1'b0, 3'($urandom), 4'(c)};
                v[7] = ($urandom_range(0, 3) == 0) && !(c inside {0, 3, 9, 14, 15});
                want <= 4'h1 << r;
                slow <= 1'($urandom);
                wr(8'h6A + 8'(r), v);
                settle(5);
                chk("legacy_irq_line_select", route_exp(v), legacy_irq_line_select);
                rd(8'h6A + 8'(r), (r == 2) ? {v[7:5], 1'b1, v[3:0]} : v);
                wr(8'h6A + 8'(r), 8'h80);
            end
        end
        want <= 4'h0;
        rd(`ADDR_EVENT_STATUS, 8'h05);
        for (int i = 0; i < 8; i++)
        begin
            s = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h8001 : 16'($urandom);
            wr(`ADDR_SOFT_IRQ_REQUEST_LOW, s[7:0]);
            wr(`ADDR_SOFT_IRQ_REQUEST_HIGH, s[15:8]);
            settle(3);
            chk("legacy_irq_line_select", s, legacy_irq_line_select);
            rd(`ADDR_SOFT_IRQ_REQUEST_LOW, s[7:0]);
            rd(`ADDR_SOFT_IRQ_REQUEST_HIGH, s[15:8]);
        end
        wr(`ADDR_SOFT_IRQ_REQUEST_LOW, 8'h00);
        wr(`ADDR_SOFT_IRQ_REQUEST_HIGH, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            v = 8'($urandom);
            v[1:0] = 2'(i);
            if (i == 4)
                v[5:2] = 4'hF;
            wr(`ADDR_SERIAL_IRQ_CONTROL, v);
            settle(3);
            chk("serial_setup", {4'h0, setup_exp(v)}, {4'h0, serial_setup});
            rd(`ADDR_SERIAL_IRQ_CONTROL, v);
        end
        // Event interrupt: raise, mask, unmask, clear, then a masked event.
        wr(`ADDR_EVENT_MASK, 8'h04);
        wr(`ADDR_EVENT_STATUS, 8'hFF);
        settle(3);
        chk("irq", 16'h0000, {15'h0, irq});
        want <= 4'h4;
        settle(6);
        chk("irq", 16'h0001, {15'h0, irq});
        rd(`ADDR_EVENT_STATUS, 8'h04);
        wr(`ADDR_EVENT_MASK, 8'h00);
        settle(3);
        chk("irq", 16'h0000, {15'h0, irq});
        wr(`ADDR_EVENT_MASK, 8'h04);
        settle(3);
        chk("irq", 16'h0001, {15'h0, irq});
        wr(`ADDR_EVENT_STATUS, 8'h04);
        settle(3);
        chk("irq", 16'h0000, {15'h0, irq});
        want <= 4'h0;
        wr(`ADDR_SERIAL_IRQ_CONTROL, 8'h03);
        settle(3);
        rd(`ADDR_EVENT_STATUS, 8'h02);
        chk("irq", 16'h0000, {15'h0, irq});
        // A second reset in mid-run must bring every register back to its reset value.
        wr(`ADDR_SOFT_IRQ_REQUEST_LOW, 8'h5A);
        settle(1);
        chk("legacy_irq_line_select", 16'h005A, legacy_irq_line_select);
        arst_n <= 1'b0;
        settle(2);
        chk("legacy_irq_line_select", 16'h0000, legacy_irq_line_select);
        chk("serial_setup", 16'h0000, {4'h0, serial_setup});
        chk("irq", 16'h0000, {15'h0, irq});
        arst_n <= 1'b1;
        rd(`ADDR_SOFT_IRQ_REQUEST_LOW, 8'h00);
        rd(`ADDR_SERIAL_IRQ_CONTROL, 8'h00);
        rd(`ADDR_ACPI_SCI_IRQ_ROUTE, 8'h80);
        rd(`ADDR_EVENT_STATUS, 8'h00);
        stop_test();
    end
endmodule

`default_nettype wire

//--- verilog/irq_route_ctrl.sv
// Interrupt routing, software requests and serial interrupt setup registers.
//
// Local design decision: strobed register access.
`include "irq_route_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module irq_route_ctrl #(
    parameter int NUM_ROUTES = 4
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Internal interrupt sources: sci, device bay, smbus, watchdog.
    input wire logic [NUM_ROUTES-1:0] src_req,
    // Requests toward the legacy interrupt controller.
    output logic [15:0] legacy_irq_line_select,
    // Serial interrupt engine setup.
    output irq_route_pkg::serial_setup_t serial_setup,
    // Event interrupt.
    output logic irq
);

    irq_route_pkg::route_t route [NUM_ROUTES];
    logic [7:0] soft_low;
    logic [7:0] soft_high;
    irq_route_pkg::serial_ctrl_t serial_ctrl;
    logic [`EVT_WIDTH-1:0] evt_status;
    logic [`EVT_WIDTH-1:0] evt_mask;
    logic smbus_prev;
    logic [15:0] route_drive [NUM_ROUTES];
    logic [15:0] next_lines;
    logic [`EVT_WIDTH-1:0] evt_set;
    logic [7:0] next_rdata;

    // Decodes a line code into a one-hot line vector; reserved codes give none.
    function automatic logic [15:0] line_decode(input logic [3:0] code);
        logic [15:0] hot;
        hot = 16'h0000;
        case (code)
            4'h0, 4'h1, 4'h2, 4'h8, 4'hD: hot = 16'h0000;
            default: hot[code] = 1'b1;
        endcase
        return hot;
    endfunction

    // Decodes the start cycle length; the reserved code falls back to the shortest pulse.
    function automatic logic [3:0] start_decode(input logic [1:0] code);
        irq_route_pkg::start_len_t len;
        logic [3:0] clocks;
        len = irq_route_pkg::start_len_t'(code);
        case (len)
            irq_route_pkg::START_SHORT: clocks = `START_CLOCKS_4;
            irq_route_pkg::START_MID: clocks = `START_CLOCKS_6;
            irq_route_pkg::START_LONG: clocks = `START_CLOCKS_8;
            default: clocks = `START_CLOCKS_4;
        endcase
        return clocks;
    endfunction

    // Routing registers, one per internal source at consecutive offsets.
    for (genvar i = 0; i < NUM_ROUTES; i++)
    begin : g_route
        always_ff @(posedge clk_sys or negedge arst_n)
        begin
            if (!arst_n)
                route[i] <= `RESET_ROUTE;
            else if (reg_wr && reg_addr == `ADDR_ACPI_SCI_IRQ_ROUTE + 8'(i))
                route[i] <= reg_wdata;
        end

        // A route only drives when enabled by a zero and the code names a real line.
        always_comb
        begin
            if (src_req[i] && !route[i].disable_n_sense)
                route_drive[i] = line_decode(route[i].line);
            else
                route_drive[i] = 16'h0000;
        end
    end

    // Software request registers.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            soft_low <= `RESET_SOFT;
            soft_high <= `RESET_SOFT;
        end
        else
        begin
            if (reg_wr && reg_addr == `ADDR_SOFT_IRQ_REQUEST_LOW)
                soft_low <= reg_wdata;
            if (reg_wr && reg_addr == `ADDR_SOFT_IRQ_REQUEST_HIGH)
                soft_high <= reg_wdata;
        end
    end

    // Serial interrupt control register.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            serial_ctrl <= `RESET_SERIAL;
        else if (reg_wr && reg_addr == `ADDR_SERIAL_IRQ_CONTROL)
            serial_ctrl <= reg_wdata;
    end

    // Merge of routed sources and software requests toward the controller.
    always_comb
    begin
        next_lines = {soft_high, soft_low};
        for (int i = 0; i < NUM_ROUTES; i++)
            next_lines = next_lines | route_drive[i];
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            legacy_irq_line_select <= 16'h0000;
        else
            legacy_irq_line_select <= next_lines;
    end

    // Setup handed to the frame engine, which runs the protocol in either mode.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            serial_setup <= '0;
        else
        begin
            serial_setup.enable <= serial_ctrl.enable;
            serial_setup.quiet <= serial_ctrl.quiet;
            serial_setup.slots <= `SLOTS_BASE + 6'(serial_ctrl.period);
            serial_setup.start_clocks <= start_decode(serial_ctrl.start_len);
        end
    end

    // Events: a reserved code written into an enabled route, a reserved start length, an SMBus request edge.
    always_comb
    begin
        evt_set = '0;
        if (reg_wr && reg_addr >= `ADDR_ACPI_SCI_IRQ_ROUTE && reg_addr <= `ADDR_WATCHDOG_IRQ_ROUTE
            && !reg_wdata[`ROUTE_DISABLE_BIT] && line_decode(reg_wdata[3:0]) == 16'h0000)
            evt_set[`EVT_RESERVED_LINE] = 1'b1;
        if (reg_wr && reg_addr == `ADDR_SERIAL_IRQ_CONTROL && reg_wdata[1:0] == 2'h3)
            evt_set[`EVT_RESERVED_START] = 1'b1;
        evt_set[`EVT_SMBUS_RISE] = src_req[`ROUTE_SMBUS] && !smbus_prev;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            smbus_prev <= 1'b0;
        else
            smbus_prev <= src_req[`ROUTE_SMBUS];
    end

    // A set in the same cycle as a write-one clear wins, so no event is lost.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            evt_status <= `EVT_WIDTH'(`RESET_EVENT);
        else if (reg_wr && reg_addr == `ADDR_EVENT_STATUS)
            evt_status <= (evt_status & ~reg_wdata[`EVT_WIDTH-1:0]) | evt_set;
        else
            evt_status <= evt_status | evt_set;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            evt_mask <= `EVT_WIDTH'(`RESET_EVENT);
        else if (reg_wr && reg_addr == `ADDR_EVENT_MASK)
            evt_mask <= reg_wdata[`EVT_WIDTH-1:0];
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            irq <= 1'b0;
        else
            irq <= |(evt_status & evt_mask);
    end

    // Read path; data stand only in the cycle after the strobe.
    always_comb
    begin
        next_rdata = 8'h00;
        case (reg_addr)
            `ADDR_ACPI_SCI_IRQ_ROUTE: next_rdata = route[0];
            `ADDR_DEVICE_BAY_IRQ_ROUTE: next_rdata = route[1];
            `ADDR_SMBUS_IRQ_ROUTE:
            begin
                next_rdata = route[`ROUTE_SMBUS];
                next_rdata[`SMBUS_STATUS_BIT] = src_req[`ROUTE_SMBUS];
            end
            `ADDR_WATCHDOG_IRQ_ROUTE: next_rdata = route[3];
            `ADDR_SOFT_IRQ_REQUEST_LOW: next_rdata = soft_low;
            `ADDR_SOFT_IRQ_REQUEST_HIGH: next_rdata = soft_high;
            `ADDR_SERIAL_IRQ_CONTROL: next_rdata = serial_ctrl;
            `ADDR_EVENT_STATUS: next_rdata = 8'(evt_status);
            `ADDR_EVENT_MASK: next_rdata = 8'(evt_mask);
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 8'h00;
    end

    // Checks on the block's own outputs.
    logic others_quiet;
    assign others_quiet = ({soft_high, soft_low} == 16'h0000) && route[1].disable_n_sense
        && route[2].disable_n_sense && route[3].disable_n_sense;

    sequence s_sci_off_write;
        reg_wr && reg_addr == `ADDR_ACPI_SCI_IRQ_ROUTE && reg_wdata[`ROUTE_DISABLE_BIT];
    endsequence

    property p_sci_disabled;
        @(posedge clk_sys) disable iff (!arst_n)
        s_sci_off_write ##1 (others_quiet && !reg_wr)
            |=> legacy_irq_line_select == 16'h0000;
    endproperty
    a_sci_disabled: assert property (p_sci_disabled) else $error("disabled sci route drove a line");

    property p_sci_line;
        @(posedge clk_sys) disable iff (!arst_n)
        src_req[0] && !route[0].disable_n_sense && route[0].line == 4'h3 |=> legacy_irq_line_select[3];
    endproperty
    a_sci_line: assert property (p_sci_line) else $error("sci route did not reach line 3");

    property p_bay_line;
        @(posedge clk_sys) disable iff (!arst_n)
        src_req[1] && !route[1].disable_n_sense && route[1].line == 4'hE |=> legacy_irq_line_select[14];
    endproperty
    a_bay_line: assert property (p_bay_line) else $error("device bay route did not reach line 14");

    property p_smbus_line;
        @(posedge clk_sys) disable iff (!arst_n)
        src_req[2] && !route[2].disable_n_sense && route[2].line == 4'h9 |=> legacy_irq_line_select[9];
    endproperty
    a_smbus_line: assert property (p_smbus_line) else $error("smbus route did not reach line 9");

    property p_smbus_status;
        @(posedge clk_sys) disable iff (!arst_n)
        reg_rd && reg_addr == `ADDR_SMBUS_IRQ_ROUTE |=> reg_rdata[4] == $past(src_req[2]);
    endproperty
    a_smbus_status: assert property (p_smbus_status) else $error("smbus status bit wrong");

    property p_wdog_line;
        @(posedge clk_sys) disable iff (!arst_n)
        src_req[3] && !route[3].disable_n_sense && route[3].line == 4'hF |=> legacy_irq_line_select[15];
    endproperty
    a_wdog_line: assert property (p_wdog_line) else $error("watchdog route did not reach line 15");

    property p_reserved_code;
        @(posedge clk_sys) disable iff (!arst_n)
        others_quiet && (route[0].line == 4'h8 || route[0].line == 4'hD) |=> legacy_irq_line_select == 16'h0000;
    endproperty
    a_reserved_code: assert property (p_reserved_code) else $error("reserved code drove a line");

    sequence s_soft_low_write;
        reg_wr && reg_addr == `ADDR_SOFT_IRQ_REQUEST_LOW ##1 !reg_wr;
    endsequence

    sequence s_soft_high_write;
        reg_wr && reg_addr == `ADDR_SOFT_IRQ_REQUEST_HIGH ##1 !reg_wr;
    endsequence

    // The written value is taken two cycles back, so no local variable is needed in the property.
    property p_soft_low;
        @(posedge clk_sys) disable iff (!arst_n)
        s_soft_low_write |=> (legacy_irq_line_select[7:0] & $past(reg_wdata, 2)) == $past(reg_wdata, 2);
    endproperty
    a_soft_low: assert property (p_soft_low) else $error("low soft request not outstanding");

    property p_soft_high;
        @(posedge clk_sys) disable iff (!arst_n)
        s_soft_high_write |=> (legacy_irq_line_select[15:8] & $past(reg_wdata, 2)) == $past(reg_wdata, 2);
    endproperty
    a_soft_high: assert property (p_soft_high) else $error("high soft request not outstanding");

    property p_serial_enable;
        @(posedge clk_sys) disable iff (!arst_n)
        reg_wr && reg_addr == `ADDR_SERIAL_IRQ_CONTROL ##1 !reg_wr
            |=> serial_setup.enable == $past(reg_wdata[7], 2) && serial_setup.quiet == $past(reg_wdata[6], 2);
    endproperty
    a_serial_enable: assert property (p_serial_enable) else $error("serial enable or mode wrong");

    property p_slots;
        @(posedge clk_sys) disable iff (!arst_n)
        reg_wr && reg_addr == `ADDR_SERIAL_IRQ_CONTROL ##1 !reg_wr
            |=> serial_setup.slots == 6'd17 + 6'($past(reg_wdata[5:2], 2));
    endproperty
    a_slots: assert property (p_slots) else $error("frame slot count wrong");

    property p_start;
        @(posedge clk_sys) disable iff (!arst_n)
        reg_wr && reg_addr == `ADDR_SERIAL_IRQ_CONTROL && reg_wdata[1:0] == 2'h2 ##1 !reg_wr
            |=> serial_setup.start_clocks == 4'h8;
    endproperty
    a_start: assert property (p_start) else $error("start length not eight clocks");

endmodule

`default_nettype wire

//--- verilog/irq_route_pkg.sv
// Types shared by the interrupt routing and serial interrupt setup block.
package irq_route_pkg;

    typedef struct packed {
        logic disable_n_sense;
        logic [2:0] spare;
        logic [3:0] line;
    } route_t;

    typedef struct packed {
        logic enable;
        logic quiet;
        logic [3:0] period;
        logic [1:0] start_len;
    } serial_ctrl_t;

    typedef struct packed {
        logic enable;
        logic quiet;
        logic [5:0] slots;
        logic [3:0] start_clocks;
    } serial_setup_t;

    typedef enum logic [1:0] {
        START_SHORT,
        START_MID,
        START_LONG,
        START_RESERVED
    } start_len_t;

endpackage

//--- verilog/irq_route_regs.svh
// Register offsets, field positions, reset values and timing figures of the interrupt routing block.
`ifndef IRQ_ROUTE_REGS_SVH
`define IRQ_ROUTE_REGS_SVH

`define ADDR_ACPI_SCI_IRQ_ROUTE 8'h6A
`define ADDR_DEVICE_BAY_IRQ_ROUTE 8'h6B
`define ADDR_SMBUS_IRQ_ROUTE 8'h6C
`define ADDR_WATCHDOG_IRQ_ROUTE 8'h6D
`define ADDR_SOFT_IRQ_REQUEST_LOW 8'h6E
`define ADDR_SOFT_IRQ_REQUEST_HIGH 8'h6F
`define ADDR_SERIAL_IRQ_CONTROL 8'h70
`define ADDR_EVENT_STATUS 8'h78
`define ADDR_EVENT_MASK 8'h79

`define RESET_ROUTE 8'h80
`define RESET_SOFT 8'h00
`define RESET_SERIAL 8'h00
`define RESET_EVENT 8'h00

`define ROUTE_DISABLE_BIT 7
`define SMBUS_STATUS_BIT 4
`define ROUTE_SMBUS 2

`define EVT_RESERVED_LINE 0
`define EVT_RESERVED_START 1
`define EVT_SMBUS_RISE 2
`define EVT_WIDTH 3

`define SLOTS_BASE 6'h11
`define START_CLOCKS_4 4'h4
`define START_CLOCKS_6 4'h6
`define START_CLOCKS_8 4'h8
`define START_CODE_4 2'h0
`define START_CODE_6 2'h1
`define START_CODE_8 2'h2

`endif
